//--- sd_params.svh
// Constant definitions for the memory device command and read-path model.
`ifndef SD_PARAMS_SVH
`define SD_PARAMS_SVH
// ********************
// Register map
// ********************
`define SD_OFF_CTRL      8'h00
`define SD_OFF_STATUS    8'h04
`define SD_OFF_MODE      8'h08
`define SD_OFF_BANKS     8'h0c
`define SD_CTRL_RESET    1'h1
`define SD_RESP_OKAY     2'h0
`define SD_RESP_SLVERR   2'h2
// ********************
// Mode register fields
// ********************
`define SD_MR_BL_LSB     0
`define SD_MR_BT_BIT     3
`define SD_MR_CL_LSB     4
`define SD_MR_DLL_BIT    8
`define SD_EMR_AL_LSB    3
`define SD_EMR_CAL_LSB   7
`define SD_BL_CODE8      3'h3
`define SD_CL_RESET      3'h3
`define SD_AL_RESET      3'h0
`define SD_AP_BIT        10
// ********************
// Timing
// ********************
`define SD_TICK_DIV      2
`define SD_DLL_LOCK_CLKS 200
`define SD_PIPE_DEPTH    16
`endif

//--- sd_pkg.sv
// Shared types for the memory device command and read-path model.
package sd_pkg;
	typedef enum logic [2:0] {
		SD_CMD_NOP,
		SD_CMD_LOAD_MODE,
		SD_CMD_REFRESH,
		SD_CMD_PRECHARGE,
		SD_CMD_ACTIVATE,
		SD_CMD_WRITE,
		SD_CMD_READ
	} sd_cmd_e;
	typedef enum logic [1:0] {
		SD_RD_IDLE,
		SD_RD_PRE,
		SD_RD_DATA,
		SD_RD_POST
	} sd_rd_state_e;
	typedef struct packed {
		logic       valid;
		logic       ap;
		logic [2:0] bank;
		logic [7:0] col;
	} sd_rdq_s;
endpackage

//--- sd_rd_path.sv
// Read data path: strobe preamble, burst elements in order, postamble, release.
`include "sd_params.svh"
module sd_rd_path (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       pre,
	input  wire logic       start,
	input  wire logic [7:0] col,
	input  wire logic       bl8,
	input  wire logic       interleave,
	output logic      [7:0] dq,
	output logic            dq_oe,
	output logic            dqs,
	output logic            dqs_n,
	output logic            dqs_oe,
	output logic            done
);
	sd_pkg::sd_rd_state_e state_reg, state_next;
	logic [2:0] idx_reg, idx_next;
	logic [7:0] col_reg, col_next;
	logic [7:0] dq_next;
	logic       dq_oe_next, dqs_next, dqs_oe_next, done_next;
	logic [2:0] last;
	logic [2:0] ord;

	always_comb begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		col_next    = col_reg;
		dq_oe_next  = 1'b0;
		dqs_next    = 1'b0;
		dqs_oe_next = 1'b0;
		done_next   = 1'b0;
		last        = bl8 ? 3'h7 : 3'h3;
		case (state_reg)
			sd_pkg::SD_RD_IDLE, sd_pkg::SD_RD_POST: begin
				state_next = sd_pkg::SD_RD_IDLE;
				if (pre) begin
					state_next  = sd_pkg::SD_RD_PRE; // RULE_16
					dqs_oe_next = 1'b1;
				end
			end
			sd_pkg::SD_RD_PRE: begin
				dqs_oe_next = 1'b1;
			end
			sd_pkg::SD_RD_DATA: begin
				dq_oe_next  = 1'b1;
				dqs_oe_next = 1'b1;
				idx_next    = idx_reg + 3'h1;
				dqs_next    = idx_next[0] == 1'b0;
				if (idx_reg == last) begin
					state_next  = sd_pkg::SD_RD_POST; // RULE_17
					dq_oe_next  = 1'b0;
					dqs_next    = 1'b0;
					done_next   = 1'b1;
				end
			end
			default: begin
				state_next = sd_pkg::SD_RD_IDLE;
			end
		endcase
		if (start) begin
			state_next  = sd_pkg::SD_RD_DATA; // RULE_18
			idx_next    = 3'h0;
			col_next    = col;
			dq_oe_next  = 1'b1;
			dqs_oe_next = 1'b1;
			dqs_next    = 1'b1;
			done_next   = 1'b0;
		end
		if (interleave) begin
			ord = col_next[2:0] ^ idx_next; // RULE_15
		end else begin
			ord = col_next[2:0] + idx_next;
		end
		if (!bl8) begin
			ord[2] = col_next[2];
		end
		dq_next = {col_next[7:3], ord};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= sd_pkg::SD_RD_IDLE;
			idx_reg   <= 3'h0;
			col_reg   <= 8'h00;
			dq        <= 8'h00;
			dq_oe     <= 1'b0;
			dqs       <= 1'b0;
			dqs_n     <= 1'b1;
			dqs_oe    <= 1'b0;
			done      <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			col_reg   <= col_next;
			dq        <= dq_next;
			dq_oe     <= dq_oe_next;
			dqs       <= dqs_next;
			dqs_n     <= ~dqs_next;
			dqs_oe    <= dqs_oe_next;
			done      <= done_next;
		end
	end
endmodule

//--- sd_dev.sv
// Memory device top: command decoder, mode registers, banks, read scheduler, bus slave.
//
// Summary of operation
// RULE_01: Host precharges all after DLL reset load.
// RULE_02: Host gives 200 clocks for DLL lock.
// RULE_03: Host issues two refreshes before mode load.
// RULE_04: Host loads base mode, DLL reset low.
// RULE_05: Host loads extended mode, calibration default.
// RULE_06: Host reloads extended mode, calibration exit.
// RULE_07: Device ready 200 clocks after DLL reset.
// RULE_08: Host activates row before any access.
// RULE_09: Host waits activate-to-access delay, rounded up.
// RULE_10: Same-bank activates spaced by row cycle.
// RULE_11: Different-bank activates spaced by bank interval.
// RULE_12: At most four activates per window.
// RULE_13: Auto precharge closes row at burst end; the code drops the close when another read starts by the end of that burst.
// RULE_14: First data after additive plus CAS latency.
// RULE_15: Further elements each half clock, programmed order.
// RULE_16: Strobe preamble low before data, postamble after; the code gives no preamble when bursts are one clock apart.
// RULE_17: Data lines released after final burst.
// RULE_18: Reads half burst apart give gapless data.
// RULE_19: Length-four bursts never truncated.
// RULE_20: Length-eight truncated only by read.
// RULE_21: Truncating read exactly two clocks later.
// RULE_22: No precharge to banks during truncation.
// RULE_23: Read data completes before a write.
// RULE_24: Bank lines select the mode register.
// RULE_25: Host tracks rows and spacing counters.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "sd_params.svh"
module sd_dev (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic      [1:0]  S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        CKE,
	input  wire logic        CS_N,
	input  wire logic        RAS_N,
	input  wire logic        CAS_N,
	input  wire logic        WE_N,
	input  wire logic [2:0]  BANK_SEL,
	input  wire logic [13:0] ADDR,
	output logic      [7:0]  DQ_O,
	output logic             DQ_OE,
	output logic             DQS_O,
	output logic             DQS_N_O,
	output logic             DQS_OE,
	output logic             READY
);
	// ********************
	// Pin synchroniser and device clock divider
	// ********************
	logic [21:0] s1_reg, s2_reg;
	logic        tick_reg;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s1_reg   <= 22'h3ffff0;
			s2_reg   <= 22'h3ffff0;
			tick_reg <= 1'b0;
		end else begin
			s1_reg   <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BANK_SEL, ADDR};
			s2_reg   <= s1_reg;
			tick_reg <= ~tick_reg;
		end
	end

	logic        p_cke;
	logic [3:0]  p_ctl;
	logic [2:0]  p_ba;
	logic [13:0] p_a;
	sd_pkg::sd_cmd_e cmd;
	assign {p_cke, p_ctl, p_ba, p_a} = s2_reg;

	always_comb begin
		case (p_ctl)
			4'h0:    cmd = sd_pkg::SD_CMD_LOAD_MODE;
			4'h1:    cmd = sd_pkg::SD_CMD_REFRESH;
			4'h2:    cmd = sd_pkg::SD_CMD_PRECHARGE;
			4'h3:    cmd = sd_pkg::SD_CMD_ACTIVATE;
			4'h4:    cmd = sd_pkg::SD_CMD_WRITE;
			4'h5:    cmd = sd_pkg::SD_CMD_READ;
			default: cmd = sd_pkg::SD_CMD_NOP;
		endcase
	end

	// ********************
	// Device state: modes, banks, lock counter, read pipe
	// ********************
	logic        en_reg, en_next;
	logic [2:0]  bl_reg, bl_next, cl_reg, cl_next, al_reg, al_next, cal_reg, cal_next;
	logic        bt_reg, bt_next, dll_seen_reg, dll_seen_next, ready_reg, ready_next;
	logic [7:0]  lock_reg, lock_next;
	logic [7:0]  open_reg, open_next;
	logic        ap_pend_reg, ap_pend_next;
	logic [2:0]  ap_bank_reg, ap_bank_next;
	sd_pkg::sd_rdq_s pipe_reg [`SD_PIPE_DEPTH];
	sd_pkg::sd_rdq_s pipe_in;
	logic        live, rd_pre, rd_start, rd_done;
	logic [3:0]  rl;
	sd_pkg::sd_rdq_s tap_data, tap_pre;

	assign live     = tick_reg && p_cke && en_reg;
	assign rl       = 4'({1'b0, al_reg} + {1'b0, cl_reg}); // RULE_14
	assign tap_data = pipe_reg[rl - 4'h1];
	assign tap_pre  = pipe_reg[rl - 4'h2];
	assign rd_start = tick_reg && tap_data.valid;
	assign rd_pre   = tick_reg && tap_pre.valid;

	always_comb begin
		pipe_in       = '0;
		bl_next       = bl_reg;
		cl_next       = cl_reg;
		al_next       = al_reg;
		bt_next       = bt_reg;
		cal_next      = cal_reg;
		dll_seen_next = dll_seen_reg;
		lock_next     = lock_reg;
		ready_next    = ready_reg;
		open_next     = open_reg;
		ap_pend_next  = ap_pend_reg;
		ap_bank_next  = ap_bank_reg;
		if (tick_reg && dll_seen_reg && !ready_reg) begin
			lock_next = lock_reg + 8'h01;
			if (lock_next == 8'(`SD_DLL_LOCK_CLKS)) begin
				ready_next = 1'b1; // RULE_07
			end
		end
		if (rd_start) begin
			ap_pend_next = tap_data.ap;
			ap_bank_next = tap_data.bank;
		end else if (rd_done && ap_pend_reg) begin
			open_next[ap_bank_reg] = 1'b0; // RULE_13
			ap_pend_next           = 1'b0;
		end
		if (live) begin
			case (cmd)
				sd_pkg::SD_CMD_LOAD_MODE: begin
					if (p_ba[1:0] == 2'h0) begin
						bl_next = p_a[`SD_MR_BL_LSB +: 3];
						bt_next = p_a[`SD_MR_BT_BIT];
						cl_next = p_a[`SD_MR_CL_LSB +: 3];
						if (p_a[`SD_MR_DLL_BIT]) begin
							dll_seen_next = 1'b1; // RULE_07
							lock_next     = 8'h00;
							ready_next    = 1'b0;
						end
					end else if (p_ba[1:0] == 2'h1) begin
						al_next  = p_a[`SD_EMR_AL_LSB +: 3];
						cal_next = p_a[`SD_EMR_CAL_LSB +: 3];
					end
				end
				sd_pkg::SD_CMD_ACTIVATE: begin
					open_next[p_ba] = 1'b1;
				end
				sd_pkg::SD_CMD_PRECHARGE: begin
					if (p_a[`SD_AP_BIT]) begin
						open_next = 8'h00;
					end else begin
						open_next[p_ba] = 1'b0;
					end
				end
				sd_pkg::SD_CMD_READ: begin
					if (ready_reg && open_reg[p_ba]) begin
						pipe_in.valid = 1'b1; // RULE_14
						pipe_in.ap    = p_a[`SD_AP_BIT];
						pipe_in.bank  = p_ba;
						pipe_in.col   = p_a[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bl_reg       <= 3'h2;
			cl_reg       <= `SD_CL_RESET;
			al_reg       <= `SD_AL_RESET;
			bt_reg       <= 1'b0;
			cal_reg      <= 3'h0;
			dll_seen_reg <= 1'b0;
			lock_reg     <= 8'h00;
			ready_reg    <= 1'b0;
			open_reg     <= 8'h00;
			ap_pend_reg  <= 1'b0;
			ap_bank_reg  <= 3'h0;
		end else begin
			bl_reg       <= bl_next;
			cl_reg       <= cl_next;
			al_reg       <= al_next;
			bt_reg       <= bt_next;
			cal_reg      <= cal_next;
			dll_seen_reg <= dll_seen_next;
			lock_reg     <= lock_next;
			ready_reg    <= ready_next;
			open_reg     <= open_next;
			ap_pend_reg  <= ap_pend_next;
			ap_bank_reg  <= ap_bank_next;
		end
	end

	assign READY = ready_reg;

	genvar gi;
	generate
		for (gi = 0; gi < `SD_PIPE_DEPTH; gi++) begin : g_pipe
			always_ff @(posedge MCLK or posedge RST) begin
				if (RST) begin
					pipe_reg[gi] <= '0;
				end else if (tick_reg) begin
					pipe_reg[gi] <= (gi == 0) ? pipe_in : pipe_reg[(gi == 0) ? 0 : gi - 1];
				end
			end
		end
	endgenerate

	sd_rd_path u_rd (
		.clk        (MCLK),
		.rst        (RST),
		.pre        (rd_pre),
		.start      (rd_start),
		.col        (tap_data.col),
		.bl8        (bl_reg == `SD_BL_CODE8),
		.interleave (bt_reg),
		.dq         (DQ_O),
		.dq_oe      (DQ_OE),
		.dqs        (DQS_O),
		.dqs_n      (DQS_N_O),
		.dqs_oe     (DQS_OE),
		.done       (rd_done)
	);

	// ********************
	// AXI4-Lite slave
	// ********************
	logic        awh_reg, awh_next, wh_reg, wh_next, bv_next, rv_next;
	logic [7:0]  awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next, rd_next;
	logic        wst_reg, wst_next;
	logic [1:0]  br_next, rr_next;

	always_comb begin
		awh_next = awh_reg;
		awa_next = awa_reg;
		wh_next  = wh_reg;
		wd_next  = wd_reg;
		wst_next = wst_reg;
		en_next  = en_reg;
		bv_next  = S_AXI_BVALID && !S_AXI_BREADY;
		br_next  = S_AXI_BRESP;
		rv_next  = S_AXI_RVALID && !S_AXI_RREADY;
		rd_next  = S_AXI_RDATA;
		rr_next  = S_AXI_RRESP;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			awh_next = 1'b1;
			awa_next = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			wh_next  = 1'b1;
			wd_next  = S_AXI_WDATA;
			wst_next = S_AXI_WSTRB[0];
		end
		if (awh_reg && wh_reg && !S_AXI_BVALID) begin
			awh_next = 1'b0;
			wh_next  = 1'b0;
			bv_next  = 1'b1;
			br_next  = `SD_RESP_OKAY;
			case (awa_reg)
				`SD_OFF_CTRL: begin
					if (wst_reg) begin
						en_next = wd_reg[0];
					end
				end
				`SD_OFF_STATUS, `SD_OFF_MODE, `SD_OFF_BANKS: begin
				end
				default: br_next = `SD_RESP_SLVERR;
			endcase
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rv_next = 1'b1;
			rr_next = `SD_RESP_OKAY;
			case (S_AXI_ARADDR)
				`SD_OFF_CTRL:   rd_next = {31'h0, en_reg};
				`SD_OFF_STATUS: rd_next = {29'h0, ap_pend_reg, dll_seen_reg, ready_reg};
				`SD_OFF_MODE:   rd_next = {16'h0, 1'b0, cal_reg, 1'b0, al_reg,
					1'b0, cl_reg, bt_reg, bl_reg};
				`SD_OFF_BANKS:  rd_next = {24'h0, open_reg};
				default: begin
					rd_next = 32'h0;
					rr_next = `SD_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			awh_reg       <= 1'b0;
			awa_reg       <= 8'h00;
			wh_reg        <= 1'b0;
			wd_reg        <= 32'h0;
			wst_reg       <= 1'b0;
			en_reg        <= `SD_CTRL_RESET;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= 2'h0;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0;
			S_AXI_RRESP   <= 2'h0;
		end else begin
			awh_reg       <= awh_next;
			awa_reg       <= awa_next;
			wh_reg        <= wh_next;
			wd_reg        <= wd_next;
			wst_reg       <= wst_next;
			en_reg        <= en_next;
			S_AXI_AWREADY <= !awh_next && !bv_next;
			S_AXI_WREADY  <= !wh_next && !bv_next;
			S_AXI_BVALID  <= bv_next;
			S_AXI_BRESP   <= br_next;
			S_AXI_ARREADY <= !rv_next;
			S_AXI_RVALID  <= rv_next;
			S_AXI_RDATA   <= rd_next;
			S_AXI_RRESP   <= rr_next;
		end
	end
endmodule

//--- sd_dev_properties.sv
// Concurrent checks on the read strobe, data release, ready timing and register bus.
module sd_dev_chk (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic DQ_OE,
	input wire logic DQS_O,
	input wire logic DQS_N_O,
	input wire logic DQS_OE,
	input wire logic READY
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Helper counters
	// ****************
	logic [4:0] run_reg, run_next;
	logic [9:0] low_reg, low_next;
	always_comb begin
		run_next = DQ_OE ? run_reg + 5'h01 : 5'h00;
		low_next = READY ? 10'h000 : low_reg + {9'h000, low_reg != 10'h3ff};
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			run_reg <= 5'h00;
			low_reg <= 10'h000;
		end else begin
			run_reg <= run_next;
			low_reg <= low_next;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	property p_pre; $rose(DQ_OE) |-> $past(DQS_OE) && !$past(DQS_O); endproperty
	a_pre: assert property (p_pre) else $error("Preamble missing.");
	property p_post; $fell(DQ_OE) |-> DQS_OE && !DQS_O; endproperty
	a_post: assert property (p_post) else $error("Postamble missing.");
	property p_comp; DQS_OE |-> DQS_N_O != DQS_O; endproperty
	a_comp: assert property (p_comp) else $error("Strobe pair equal.");
	property p_alt; DQ_OE && $past(DQ_OE) |-> DQS_O != $past(DQS_O); endproperty
	a_alt: assert property (p_alt) else $error("Strobe did not toggle.");
	property p_first; $rose(DQ_OE) |-> DQS_O; endproperty
	a_first: assert property (p_first) else $error("First element strobe low.");
	property p_quad; $fell(DQ_OE) |-> run_reg[1:0] == 2'h0 && run_reg != 5'h00; endproperty
	a_quad: assert property (p_quad) else $error("Burst cut off a boundary.");
	property p_fall; $fell(DQS_OE) |-> !$past(DQ_OE); endproperty
	a_fall: assert property (p_fall) else $error("Strobe released with data.");
	property p_rdy; $rose(READY) |-> low_reg >= 10'h18e; endproperty
	a_rdy: assert property (p_rdy) else $error("Ready too early.");
	property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_rlat: assert property (p_rlat) else $error("Read answer late.");
	property p_arq; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
	a_arq: assert property (p_arq) else $error("Read address taken early.");
	c_gap: cover property ($fell(DQ_OE) && run_reg == 5'h08);
	c_trunc: cover property ($fell(DQ_OE) && run_reg == 5'h0c);
	c_rdy: cover property ($rose(READY));
	c_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind sd_dev sd_dev_chk u_chk (.MCLK, .RST, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
	.S_AXI_RREADY, .DQ_OE, .DQS_O, .DQS_N_O, .DQS_OE, .READY);

//--- sd_ctl_model.sv
// Memory controller model that drives the device command pins.
module sd_ctl_model (
	input  wire logic        MCLK,
	output logic             CKE,
	output logic             CS_N,
	output logic             RAS_N,
	output logic             CAS_N,
	output logic             WE_N,
	output logic      [2:0]  BANK_SEL,
	output logic      [13:0] ADDR
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Command issue
	// ****************
	parameter int T_RCD = 6;
	logic ph = 1'b0;
	initial begin
		CKE = 1'b1;
		{CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
		BANK_SEL = 3'h0;
		ADDR = 14'h0000;
	end
	always @(posedge MCLK) ph <= ~ph;
	// Each command is held two cycles on an even edge, then two cycles of no-operation.
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		do @(posedge MCLK); while (ph);
		{CS_N, RAS_N, CAS_N, WE_N} <= c;
		BANK_SEL <= b;
		ADDR <= a;
		repeat (2) @(posedge MCLK);
		{CS_N, RAS_N, CAS_N, WE_N} <= 4'hf;
		BANK_SEL <= ~b;
		ADDR <= ~a;
	endtask
	task automatic init(input logic [13:0] mr);
		cmd(4'h2, 3'h0, 14'h0400);
		cmd(4'h1, 3'h0, 14'h0000);
		cmd(4'h1, 3'h0, 14'h0000);
		cmd(4'h0, 3'h0, mr);
		cmd(4'h0, 3'h1, 14'h0380);
		cmd(4'h0, 3'h1, 14'h0000);
	endtask
	task automatic act(input logic [2:0] b, input logic [13:0] row);
		cmd(4'h3, b, row);
		repeat (T_RCD) cmd(4'hf, 3'h0, 14'h0000);
	endtask
	// Only reads are issued, two ticks apart at the closest, and never a precharge between.
	task automatic rd(input logic [2:0] b, input logic [7:0] col, input logic ap);
		cmd(4'h5, b, {3'h0, ap, 2'h0, col});
	endtask
endmodule

//--- tb_sd_dev.sv
// Testbench for the memory device: start-up, read bursts, truncation and register bus.
`include "sd_params.svh"
module tb_sd_dev;
	timeunit 1ns;
	timeprecision 100ps;
	logic        MCLK, RST, CKE, CS_N, RAS_N, CAS_N, WE_N, DQ_OE, DQS_O, DQS_N_O, DQS_OE;
	logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
	logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, READY;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
	logic [2:0]  BANK_SEL;
	logic [3:0]  S_AXI_WSTRB;
	logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, DQ_O;
	logic [7:0]  q[$];
	logic [13:0] ADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d;
	int          mismatches, checked, lat, lat3;
	int          cyc = 0;
	sd_dev dut (
		.MCLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
		.S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
		.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
		.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N,
		.BANK_SEL, .ADDR, .DQ_O, .DQ_OE, .DQS_O, .DQS_N_O, .DQS_OE, .READY
	);
	sd_ctl_model u_ctl (.MCLK, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BANK_SEL, .ADDR);
	// ****************
	// Shared tasks
	// ****************
	always #2 MCLK = ~MCLK;
	always @(posedge MCLK) cyc <= cyc + 1;
	task automatic chk(input logic c, input string m);
		checked++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic test_done();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic hang();
		chk(1'b0, "wait expired");
		test_done();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1 && n < 50);
		rsp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
		if (n >= 50) hang();
	endtask
	task automatic axr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1 && n < 50);
		rd_d = S_AXI_RDATA;
		rsp = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
		if (n >= 50) hang();
	endtask
	// Collects a burst against q; an empty q means no data may appear.
	task automatic grab();
		int k;
		logic p;
		k = 0;
		p = 1'b0;
		@(negedge MCLK);
		while (DQ_OE !== 1'b1 && k < 80) begin
			p = DQS_OE && !DQS_O;
			@(negedge MCLK);
			k++;
		end
		lat = k;
		if (q.size() == 0) begin
			chk(k == 80, "read not refused");
			return;
		end
		if (k == 80) hang();
		chk(p, "preamble");
		foreach (q[i]) begin
			chk(DQ_O === q[i] && DQ_OE === 1'b1 && DQS_O === (i % 2 == 0), "data");
			@(negedge MCLK);
		end
		chk(DQ_OE === 1'b0 && DQS_OE === 1'b1 && DQS_O === 1'b0, "postamble");
		@(negedge MCLK);
		chk(DQS_OE === 1'b0 && DQ_OE === 1'b0, "release");
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_init();
		int t0;
		u_ctl.cmd(4'h0, 3'h0, 14'h0100);
		t0 = cyc;
		u_ctl.init(14'h0032);
		u_ctl.act(3'h1, 14'h0123);
		q = {};
		u_ctl.rd(3'h1, 8'h10, 1'b0);
		grab();
		while (READY !== 1'b1 && cyc - t0 < 600) @(posedge MCLK);
		chk(cyc - t0 >= 2 * `SD_DLL_LOCK_CLKS && cyc - t0 <= 2 * `SD_DLL_LOCK_CLKS + 4, "ready time");
		$display("t_init done");
	endtask
	task automatic t_lat();
		q = {8'h25, 8'h26, 8'h27, 8'h24};
		u_ctl.rd(3'h1, 8'h25, 1'b0);
		grab();
		lat3 = lat;
		u_ctl.cmd(4'h0, 3'h0, 14'h0052);
		u_ctl.rd(3'h1, 8'h25, 1'b0);
		grab();
		chk(lat == lat3 + 4, "cas latency");
		u_ctl.cmd(4'h0, 3'h1, 14'h0008);
		u_ctl.rd(3'h1, 8'h25, 1'b0);
		grab();
		chk(lat == lat3 + 6, "additive latency");
		u_ctl.cmd(4'h0, 3'h1, 14'h0000);
		u_ctl.cmd(4'h0, 3'h0, 14'h0032);
		$display("t_lat done");
	endtask
	task automatic t_gap();
		q = {8'h40, 8'h41, 8'h42, 8'h43, 8'h83, 8'h80, 8'h81, 8'h82};
		u_ctl.rd(3'h1, 8'h40, 1'b0);
		u_ctl.rd(3'h1, 8'h83, 1'b0);
		grab();
		$display("t_gap done");
	endtask
	task automatic t_trunc();
		u_ctl.cmd(4'h0, 3'h0, 14'h003b);
		q = {8'h05, 8'h04, 8'h07, 8'h06, 8'h1a, 8'h1b, 8'h18, 8'h19, 8'h1e, 8'h1f, 8'h1c, 8'h1d};
		u_ctl.rd(3'h1, 8'h05, 1'b0);
		u_ctl.rd(3'h1, 8'h1a, 1'b0);
		grab();
		u_ctl.cmd(4'h0, 3'h0, 14'h0032);
		$display("t_trunc done");
	endtask
	task automatic t_axi();
		axw(`SD_OFF_CTRL, 32'h0000_0000);
		q = {};
		u_ctl.rd(3'h1, 8'h22, 1'b0);
		grab();
		axw(`SD_OFF_CTRL, 32'h0000_0001);
		chk(rsp === `SD_RESP_OKAY, "ctrl response");
		S_AXI_WSTRB <= 4'he;
		axw(`SD_OFF_CTRL, 32'h0000_0000);
		S_AXI_WSTRB <= 4'hf;
		axr(`SD_OFF_CTRL);
		chk(rd_d === 32'h0000_0001 && rsp === `SD_RESP_OKAY, "lane zero gates enable");
		axw(8'h10, 32'h0000_0000);
		chk(rsp === `SD_RESP_SLVERR, "unmapped write");
		axw(`SD_OFF_STATUS, 32'h0000_0000);
		chk(rsp === `SD_RESP_OKAY, "status write response");
		axr(`SD_OFF_STATUS);
		chk(rd_d === 32'h0000_0003 && rsp === `SD_RESP_OKAY, "status ready");
		axr(`SD_OFF_MODE);
		chk(rd_d === 32'h0000_0032, "mode fields");
		axr(8'h10);
		chk(rsp === `SD_RESP_SLVERR && rd_d === 32'h0000_0000, "unmapped");
		$display("t_axi done");
	endtask
	task automatic t_ap();
		axr(`SD_OFF_BANKS);
		chk(rd_d[1] === 1'b1, "row left open");
		q = {8'h31, 8'h32, 8'h33, 8'h30};
		u_ctl.rd(3'h1, 8'h31, 1'b1);
		grab();
		axr(`SD_OFF_BANKS);
		chk(rd_d[1] === 1'b0, "row closed");
		q = {};
		u_ctl.rd(3'h1, 8'h31, 1'b0);
		grab();
		$display("t_ap done");
	endtask
	initial begin
		{MCLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h08;
		{S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = 18'h00000;
		S_AXI_WDATA = 32'h0000_0000;
		S_AXI_WSTRB = 4'hf;
		{mismatches, checked} = {32'h0, 32'h0};
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		repeat (4) @(posedge MCLK);
		t_init();
		t_lat();
		t_gap();
		t_trunc();
		t_axi();
		t_ap();
		test_done();
	end
endmodule
